// [core/pwm_channel_value_update.sv]
`timescale 1ns/10ps
// What this block does
// - Edge PWM loads buffer at modulo-1 to modulo
// - Free-running edge PWM loads at FFFE to FFFF
// - Center PWM value equal modulo gives full duty
// - Center PWM value modulo-1 gives almost full duty
// - Zero to nonzero waits for new period
// - Nonzero to zero finishes period with old duty
// - Debug control write clears modulo byte pairing
// - Edge PWM output frozen while clock deselected
// - Edge select zero leaves pin to port
// - Overflow flag at modulo to zero wrap
// - Center overflow flag at up-to-down turn
module pwm_channel_value_update
    import pwm_update_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // Debug state
    input wire logic background_debug_mode,
    // Channel pin and interrupt
    output logic chan_pin_out,
    output logic chan_pin_oe,
    output logic irq
);
    import pwm_update_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rd_pend;
        logic [7:0] rd_addr;
        logic [1:0] clock_source_select;
        logic center_align_select;
        logic [1:0] edge_level_select;
        logic edge_aligned_pwm_output_en;
        logic [15:0] counter_modulo;
        logic [15:0] mod_buf;
        logic mod_hi_seen;
        logic mod_lo_seen;
        logic [15:0] channel_value;
        logic [15:0] val_buf;
        logic val_hi_seen;
        logic val_lo_seen;
        logic [15:0] count;
        logic count_down;
        logic [3:0] div;
        logic edge_aligned_pwm_output_out;
        logic [1:0] status;
        logic [1:0] mask;
        logic [31:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic tick;
    logic at_top;
    logic [15:0] top;
    logic [15:0] top_m1;
    logic wr_now;
    logic [31:0] rd_mux;
    logic ovf_ev;
    logic chan_ev;
    logic load_val;

    assign top = (s_reg.counter_modulo == MODULO_RESET) ? COUNT_TOP : s_reg.counter_modulo;
    assign top_m1 = (s_reg.counter_modulo == MODULO_RESET) ? COUNT_TOP_M1 :
        16'(s_reg.counter_modulo - 16'h0001);
    assign at_top = (s_reg.count == top);
    // Clock select 1 counts every bus cycle, other nonzero values use the divider
    assign tick = (s_reg.clock_source_select == 2'h1) ||
        ((s_reg.clock_source_select != CLKSEL_OFF) && (s_reg.div == SLOW_DIV_MAX));
    assign wr_now = s_reg.wr_pend;

    always_comb begin
        case (s_reg.rd_addr)
            OFS_TIMER_CTRL: rd_mux = {29'h0, s_reg.center_align_select,
                s_reg.clock_source_select};
            OFS_MODULO: rd_mux = {16'h0, s_reg.counter_modulo};
            OFS_CHAN_CTRL: rd_mux = {29'h0, s_reg.edge_aligned_pwm_output_en, s_reg.edge_level_select};
            OFS_CHAN_VALUE: rd_mux = {16'h0, s_reg.channel_value};
            OFS_COUNTER: rd_mux = {15'h0, s_reg.count_down, s_reg.count};
            OFS_IRQ_STATUS: rd_mux = {30'h0, s_reg.status};
            OFS_IRQ_MASK: rd_mux = {30'h0, s_reg.mask};
            OFS_DEBUG: rd_mux = {28'h0, s_reg.val_lo_seen, s_reg.val_hi_seen,
                s_reg.mod_lo_seen, s_reg.mod_hi_seen};
            default: rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        ovf_ev = 1'b0;
        chan_ev = 1'b0;
        load_val = 1'b0;
        // Reads take one wait state so that read data comes from a flip-flop
        s_next.wr_pend = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite &&
            (hsize == HSIZE_WORD);
        s_next.rd_pend = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
        if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            s_next.wr_addr = haddr;
            s_next.rd_addr = haddr;
        end
        if (s_reg.rd_pend) begin
            s_next.rdata = rd_mux;
        end

        // Prescaler
        if (s_reg.clock_source_select == CLKSEL_OFF || s_reg.div == SLOW_DIV_MAX) begin
            s_next.div = 4'h0;
        end else begin
            s_next.div = 4'(s_reg.div + 4'h1);
        end

        // Counter, overflow and waveform
        if (tick) begin
            if (s_reg.center_align_select) begin
                if (!s_reg.count_down && at_top) begin
                    s_next.count_down = 1'b1;
                    s_next.count = 16'(s_reg.count - 16'h0001);
                    ovf_ev = 1'b1;
                    load_val = 1'b1;
                end else if (s_reg.count_down && s_reg.count == 16'h0000) begin
                    s_next.count_down = 1'b0;
                    s_next.count = 16'h0001;
                end else if (s_reg.count_down) begin
                    s_next.count = 16'(s_reg.count - 16'h0001);
                end else begin
                    s_next.count = 16'(s_reg.count + 16'h0001);
                end
                // Output high while count is below value; value at modulo holds full duty
                if (s_reg.channel_value >= top) begin
                    s_next.edge_aligned_pwm_output_out = 1'b1;
                end else begin
                    s_next.edge_aligned_pwm_output_out = (s_next.count < s_reg.channel_value);
                end
                if (s_next.count == s_reg.channel_value) begin
                    chan_ev = 1'b1;
                end
            end else begin
                s_next.count_down = 1'b0;
                if (at_top) begin
                    s_next.count = 16'h0000;
                    ovf_ev = 1'b1;
                end else begin
                    s_next.count = 16'(s_reg.count + 16'h0001);
                end
                if (s_reg.count == top_m1) begin
                    load_val = 1'b1;
                end
                // Only refreshed on a counter tick, so it freezes when clock is off
                if (s_reg.edge_aligned_pwm_output_en) begin
                    s_next.edge_aligned_pwm_output_out = (s_next.count < s_reg.channel_value);
                end
                if (s_next.count == s_reg.channel_value) begin
                    chan_ev = 1'b1;
                end
            end
        end
        if (load_val && s_reg.val_hi_seen && s_reg.val_lo_seen) begin
            s_next.channel_value = s_reg.val_buf;
            s_next.val_hi_seen = 1'b0;
            s_next.val_lo_seen = 1'b0;
        end

        // Register writes
        if (wr_now) begin
            case (s_reg.wr_addr)
                OFS_TIMER_CTRL: begin
                    s_next.clock_source_select = hwdata[CLKSEL_LSB +: 2];
                    s_next.center_align_select = hwdata[CENTER_BIT];
                    if (background_debug_mode) begin
                        s_next.mod_hi_seen = 1'b0;
                        s_next.mod_lo_seen = 1'b0;
                    end
                end
                OFS_MODULO: begin
                    if (hwdata[BYTE_HI_BIT]) begin
                        s_next.mod_buf[15:8] = hwdata[15:8];
                        s_next.mod_hi_seen = 1'b1;
                    end
                    if (hwdata[BYTE_LO_BIT]) begin
                        s_next.mod_buf[7:0] = hwdata[7:0];
                        s_next.mod_lo_seen = 1'b1;
                    end
                end
                OFS_CHAN_CTRL: begin
                    s_next.edge_level_select = hwdata[ELS_LSB +: 2];
                    s_next.edge_aligned_pwm_output_en = hwdata[EDGE_ALIGNED_PWM_OUTPUT_EN_BIT];
                end
                OFS_CHAN_VALUE: begin
                    if (hwdata[BYTE_HI_BIT]) begin
                        s_next.val_buf[15:8] = hwdata[15:8];
                        s_next.val_hi_seen = 1'b1;
                    end
                    if (hwdata[BYTE_LO_BIT]) begin
                        s_next.val_buf[7:0] = hwdata[7:0];
                        s_next.val_lo_seen = 1'b1;
                    end
                end
                OFS_COUNTER: begin
                    s_next.count = 16'h0000;
                    s_next.count_down = 1'b0;
                    s_next.div = 4'h0;
                end
                OFS_IRQ_STATUS: s_next.status = s_reg.status & ~hwdata[1:0];
                OFS_IRQ_MASK: s_next.mask = hwdata[1:0];
                default: begin
                end
            endcase
        end
        // Modulo takes effect once both bytes have arrived
        if (s_next.mod_hi_seen && s_next.mod_lo_seen) begin
            s_next.counter_modulo = s_next.mod_buf;
            s_next.mod_hi_seen = 1'b0;
            s_next.mod_lo_seen = 1'b0;
        end
        // Set wins over a same-cycle clear
        if (ovf_ev) begin
            s_next.status[IRQ_OVF_BIT] = 1'b1;
        end
        if (chan_ev) begin
            s_next.status[IRQ_CHAN_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hrdata = s_reg.rdata;
    // Low only in the first data-phase cycle of a read
    assign hreadyout = !s_reg.rd_pend;
    assign hresp = RESP_OKAY;
    assign irq = |(s_reg.status & s_reg.mask);
    // Output active-low when edge select 01, high-true otherwise; 00 releases the pin
    assign chan_pin_oe = s_reg.edge_aligned_pwm_output_en && (s_reg.edge_level_select != ELS_OFF);
    assign chan_pin_out = (s_reg.edge_level_select == 2'h1) ? ~s_reg.edge_aligned_pwm_output_out : s_reg.edge_aligned_pwm_output_out;

    sequence seq_edge_load;
        tick && !s_reg.center_align_select && s_reg.count == top_m1 &&
            s_reg.val_hi_seen && s_reg.val_lo_seen && !wr_now;
    endsequence

    AST_EDGE_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        seq_edge_load |=> s_reg.channel_value == $past(s_reg.val_buf))
        else $error("edge load missed");
    AST_FREE_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        (seq_edge_load and s_reg.counter_modulo == 16'h0000) |=> s_reg.count == 16'hFFFF)
        else $error("free load point wrong");
    AST_CENTER_FULL: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && s_reg.center_align_select && s_reg.channel_value >= top) |=> s_reg.edge_aligned_pwm_output_out)
        else $error("full duty lost");
    AST_CENTER_NEAR: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && s_reg.center_align_select && s_reg.channel_value == top_m1 &&
        s_next.count < top_m1) |=> s_reg.edge_aligned_pwm_output_out)
        else $error("near full duty lost");
    AST_HOLD_VALUE: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.center_align_select && !(tick && !s_reg.count_down && at_top)) |=>
        s_reg.channel_value == $past(s_reg.channel_value))
        else $error("center value changed mid period");
    AST_BDM_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_now && s_reg.wr_addr == OFS_TIMER_CTRL && background_debug_mode) |=>
        !s_reg.mod_hi_seen && !s_reg.mod_lo_seen)
        else $error("modulo pairing not cleared");
    AST_FROZEN: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.clock_source_select == CLKSEL_OFF) |=> $stable(s_reg.edge_aligned_pwm_output_out))
        else $error("output moved with clock off");
    AST_PIN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        s_reg.edge_level_select == ELS_OFF |-> !chan_pin_oe)
        else $error("pin driven with select zero");
    AST_OVF_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && !s_reg.center_align_select && at_top) |=> s_reg.status[IRQ_OVF_BIT] &&
        s_reg.count == 16'h0000)
        else $error("overflow flag missed");
    AST_OVF_CENTER: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && s_reg.center_align_select && !s_reg.count_down && at_top) |=>
        s_reg.status[IRQ_OVF_BIT] && s_reg.count_down)
        else $error("center overflow missed");

    // Buffered value may only move at the update points of its mode
    sequence seq_center_turn;
        tick && s_reg.center_align_select && !s_reg.count_down && at_top;
    endsequence

    AST_CENTER_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        (seq_center_turn and (s_reg.val_hi_seen && s_reg.val_lo_seen)) |=>
        s_reg.channel_value == $past(s_reg.val_buf))
        else $error("center load missed");
    AST_ZERO_LATE: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.center_align_select && s_reg.channel_value != 16'h0000 &&
        !(tick && !s_reg.count_down && at_top)) |=> s_reg.channel_value != 16'h0000)
        else $error("zero duty applied mid period");
    AST_EDGE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_reg.center_align_select && !(tick && s_reg.count == top_m1)) |=>
        s_reg.channel_value == $past(s_reg.channel_value))
        else $error("edge value changed mid period");
    AST_WRITE_BUFFER: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_now && s_reg.wr_addr == OFS_CHAN_VALUE && !load_val) |=>
        s_reg.channel_value == $past(s_reg.channel_value))
        else $error("channel write bypassed buffer");
    AST_FREE_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && !s_reg.center_align_select && s_reg.counter_modulo == MODULO_RESET &&
        s_reg.count == COUNT_TOP) |=> s_reg.count == 16'h0000 && s_reg.status[IRQ_OVF_BIT])
        else $error("free running wrap wrong");
    AST_COUNT_FROZEN: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.clock_source_select == CLKSEL_OFF && !wr_now) |=>
        $stable(s_reg.count))
        else $error("counter moved with clock off");
    AST_PIN_ON: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.edge_aligned_pwm_output_en && s_reg.edge_level_select != ELS_OFF) |->
        chan_pin_oe)
        else $error("pin not driven when selected");
    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (rst)
        (ovf_ev && wr_now && s_reg.wr_addr == OFS_IRQ_STATUS) |=>
        s_reg.status[IRQ_OVF_BIT])
        else $error("overflow lost to clear");
    // One wait state per read, so a write just before it is already visible
    AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (rst)
        s_reg.rd_pend |-> !hreadyout ##1 (hreadyout && hrdata == $past(rd_mux)))
        else $error("read data phase wrong");
    AST_MOD_PAIR: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_now && s_reg.wr_addr == OFS_MODULO && hwdata[BYTE_HI_BIT] &&
        hwdata[BYTE_LO_BIT]) |=> s_reg.counter_modulo == $past(hwdata[15:0]))
        else $error("modulo pair not applied");
    AST_DIV_RATE: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.clock_source_select[1] && s_reg.div != SLOW_DIV_MAX) |-> !tick)
        else $error("slow clock ticked early");
endmodule

// [core/pwm_update_pkg.sv]
package pwm_update_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODULO = 8'h04;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h08;
    localparam logic [7:0] OFS_CHAN_VALUE = 8'h0C;
    localparam logic [7:0] OFS_COUNTER = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_DEBUG = 8'h1C;
    // timer_status_control fields
    localparam int CLKSEL_LSB = 0;
    localparam int CENTER_BIT = 2;
    // channel_status_control fields
    localparam int ELS_LSB = 0;
    localparam int EDGE_ALIGNED_PWM_OUTPUT_EN_BIT = 2;
    // Status / mask bits
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_CHAN_BIT = 1;
    // Byte write flags sit above the 16-bit value so that any byte value can be written
    localparam int BYTE_HI_BIT = 16;
    localparam int BYTE_LO_BIT = 17;
    localparam logic [15:0] MODULO_RESET = 16'h0000;
    localparam logic [15:0] CHAN_VALUE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [15:0] COUNT_TOP_M1 = 16'hFFFE;
    localparam logic [1:0] CLKSEL_OFF = 2'h0;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Prescale divider count for clock select 2 (slower source)
    localparam logic [3:0] SLOW_DIV_MAX = 4'h7;
endpackage

// [test/pwm_channel_value_update_tb.sv]
`timescale 1ns/10ps
module pwm_channel_value_update_tb;
    import pwm_update_pkg::*;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
    // Edge period is modulo plus one, center period twice the modulo
    localparam int P = 776;
    localparam int CP = 1550;
    // Clock, reset and bus
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
    // Debug, pin and interrupt
    logic background_debug_mode = 1'b0;
    logic chan_pin_out;
    logic chan_pin_oe;
    logic irq;
    logic [31:0] r;
    logic p;
    int fails = 0;
    int checks = 0;
    int hi;
    int i;

    pwm_channel_value_update dut (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .background_debug_mode(background_debug_mode), .chan_pin_out(chan_pin_out),
        .chan_pin_oe(chan_pin_oe), .irq(irq)
    );

    always #10 clk_sys = ~clk_sys;

    // Single word transfer; read data is taken at the edge that ends the data phase
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        if (!w) r = hrdata;
    endtask

    task duty(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (chan_pin_out === 1'b1) hi++;
        end
    endtask

    task poll_ovf;
        for (i = 0; i < 500; i++) begin
            xfer(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
            if (r[IRQ_OVF_BIT] === 1'b1) break;
        end
    endtask

    task test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Budget well above the roughly 29000 cycles the sequence needs
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        test_done;
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        xfer(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK("status", 32'h0000_0000, r)
        `CHK("pin_oe", 1'b0, chan_pin_oe)
        xfer(1'b0, 8'h20, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, r)
        xfer(1'b1, OFS_MODULO, 32'h0003_0307);
        xfer(1'b1, OFS_CHAN_CTRL, 32'h0000_0004);
        @(posedge clk_sys);
        `CHK("pin_oe", 1'b0, chan_pin_oe)
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0003_0305);
        xfer(1'b1, OFS_TIMER_CTRL, 32'h0000_0001);
        poll_ovf;
        `CHK("overflow", 1'b1, r[IRQ_OVF_BIT])
        xfer(1'b1, OFS_CHAN_CTRL, 32'h0000_0006);
        @(posedge clk_sys);
        `CHK("pin_oe", 1'b1, chan_pin_oe)
        xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        `CHK("irq", 1'b1, irq)
        xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        `CHK("irq masked", 1'b0, irq)
        duty(2 * P);
        duty(P);
        `CHK("edge duty", P - 3, hi)
        // Low byte alone must not reach the active value
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0002_0002);
        duty(2 * P);
        duty(P);
        `CHK("half write", P - 3, hi)
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0001_0100);
        duty(2 * P);
        duty(P);
        `CHK("paired duty", 32'h0000_0102, hi)
        xfer(1'b1, OFS_TIMER_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clk_sys);
        p = chan_pin_out;
        xfer(1'b1, OFS_CHAN_CTRL, 32'h0000_0006);
        duty(40);
        `CHK("frozen pin", p ? 40 : 0, hi)
        xfer(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
        xfer(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK("cleared", 1'b0, r[IRQ_OVF_BIT])
        xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        `CHK("irq cleared", 1'b0, irq)
        xfer(1'b1, OFS_CHAN_CTRL, 32'h0000_0004);
        @(posedge clk_sys);
        `CHK("pin_oe off", 1'b0, chan_pin_oe)
        // Control write in debug drops the pending high byte
        background_debug_mode <= 1'b1;
        xfer(1'b1, OFS_MODULO, 32'h0001_0100);
        xfer(1'b1, OFS_TIMER_CTRL, 32'h0000_0000);
        xfer(1'b1, OFS_MODULO, 32'h0002_0055);
        xfer(1'b0, OFS_MODULO, 32'h0000_0000);
        `CHK("modulo", 16'h0307, r[15:0])
        background_debug_mode <= 1'b0;
        xfer(1'b1, OFS_CHAN_CTRL, 32'h0000_0006);
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0003_0307);
        xfer(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
        xfer(1'b1, OFS_TIMER_CTRL, 32'h0000_0005);
        poll_ovf;
        `CHK("center overflow", 1'b1, r[IRQ_OVF_BIT])
        duty(2 * CP);
        duty(2 * CP);
        `CHK("full duty", 2 * CP, hi)
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0003_0306);
        duty(2 * CP);
        duty(2 * CP);
        `CHK("near full", 1'b1, hi > 2 * CP - 8 && hi < 2 * CP)
        // Zero waits for the next turn, and so does a new nonzero value
        xfer(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
        poll_ovf;
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0003_0000);
        xfer(1'b0, OFS_CHAN_VALUE, 32'h0000_0000);
        `CHK("old value kept", 16'h0306, r[15:0])
        xfer(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
        poll_ovf;
        xfer(1'b0, OFS_CHAN_VALUE, 32'h0000_0000);
        `CHK("zero applied", 16'h0000, r[15:0])
        xfer(1'b1, OFS_CHAN_VALUE, 32'h0003_0307);
        xfer(1'b0, OFS_CHAN_VALUE, 32'h0000_0000);
        `CHK("zero kept", 16'h0000, r[15:0])
        duty(1000);
        `CHK("zero duty", 0, hi)
        xfer(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
        poll_ovf;
        duty(2 * CP);
        `CHK("new duty", 2 * CP, hi)
        // Slow clock select ticks once every eight bus cycles
        xfer(1'b1, OFS_TIMER_CTRL, 32'h0000_0002);
        xfer(1'b1, OFS_COUNTER, 32'h0000_0000);
        xfer(1'b0, OFS_COUNTER, 32'h0000_0000);
        hi = r[15:0];
        repeat (76) @(posedge clk_sys);
        xfer(1'b0, OFS_COUNTER, 32'h0000_0000);
        `CHK("slow rate", 10, r[15:0] - hi)
        test_done;
    end
endmodule
